// file: core/icdl_axil_slave.sv
// AXI4-Lite slave front end of the recovery lane
`timescale 1ns/1ns
`include "icdl_map.svh"
module icdl_axil_slave (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Write channels
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side
  output logic wr_stb,
  output logic [3:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_held;
  logic w_held;

  assign awready = ce && !aw_held && !bvalid;
  assign wready = ce && !w_held && !bvalid;
  assign arready = ce && !rvalid;
  assign wr_stb = ce && aw_held && w_held && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      wr_addr <= 4'h0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      wr_addr <= awaddr;
    end else if (wr_stb) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end else if (wr_stb) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `ICDL_RESP_OKAY;
    end else if (wr_stb) begin
      bvalid <= 1'b1;
      bresp <= wr_ok ? `ICDL_RESP_OKAY : `ICDL_RESP_SLVERR;
    end else if (ce && bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read data is sampled from the decode at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `ICDL_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_data;
      rresp <= rd_ok ? `ICDL_RESP_OKAY : `ICDL_RESP_SLVERR;
    end else if (ce && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule // icdl_axil_slave

// file: core/icdl_lane.sv
// Clock and data recovery lane with serialiser and register slave
`timescale 1ns/1ns
`include "icdl_map.svh"
module icdl_lane #(
  parameter bit WORD_ROTATE_OPTION = 1'b1,
  parameter bit DIAG_OPTION = 1'b1,
  parameter int TAP_PS = 25,
  parameter int WORD_W = `ICDL_WORD_BITS
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Register bus
  input wire logic [3:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [3:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // Serial pins
  input wire logic rx_p,
  input wire logic rx_n,
  output logic tx_p,
  output logic tx_n,
  // Lane control pins
  input wire logic stream_valid,
  input wire logic bank_clock_pause,
  input wire logic word_rotate,
  // Fabric receive side
  output logic rx_fabric_clk,
  output logic [WORD_W-1:0] rx_word,
  output logic rx_word_valid,
  output logic lock_valid,
  // Fabric transmit side
  output logic tx_fabric_clk,
  input wire logic [WORD_W-1:0] tx_word,
  output logic tx_word_take,
  // Diagnostics
  output logic [10:0] delay_line_a_select,
  output logic [10:0] delay_line_b_select,
  output logic monitor_early_flag,
  output logic monitor_late_flag,
  output logic recovery_locked,
  output logic phase_switch,
  output logic shift_direction_flag
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  localparam int QTR_CODE = `ICDL_QTR_PS / TAP_PS;
  if (TAP_PS < 1 || QTR_CODE > 127) begin : g_bad_tap
    $error("TAP_PS gives a delay code outside 7 bits");
  end
  if (WORD_W != `ICDL_WORD_BITS) begin : g_bad_word // RULE14
    $error("Only a ratio of five is supported");
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  assign pin_raw = {word_rotate, bank_clock_pause, stream_valid, rx_n, rx_p};
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sync1[i] <= 1'b0;
        sync2[i] <= 1'b0;
      end else if (ce) begin
        sync1[i] <= pin_raw[i];
        sync2[i] <= sync1[i];
      end
    end
  end
  logic rx_bit;
  assign rx_bit = sync2[0] & ~sync2[1];

  // ----------------------------------------
  // Registers and resets
  // ----------------------------------------
  logic soft_reset;
  logic [2:0] window;
  logic lane_rst;
  logic pause_q;
  logic rot_q;
  logic resync;
  logic rotate_stb;
  assign lane_rst = !aresetn || soft_reset; // RULE6
  assign resync = lane_rst || (ce && (pause_q ^ sync2[3])); // RULE18
  assign rotate_stb = WORD_ROTATE_OPTION && (rot_q ^ sync2[4]) && sync2[4]; // RULE5

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pause_q <= 1'b0;
      rot_q <= 1'b0;
    end else if (ce) begin
      pause_q <= sync2[3];
      rot_q <= sync2[4];
    end
  end

  // ----------------------------------------
  // Clock generator and delay loop
  // ----------------------------------------
  logic [1:0] phase;
  logic [6:0] dll_code;
  logic dll_locked;
  logic [3:0] dll_cnt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 2'h0;
    end else if (ce) begin
      phase <= phase + 2'h1; // RULE3
    end
  end

  // Only the bus reset reaches the delay loop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dll_cnt <= 4'h0;
      dll_code <= 7'h0;
      dll_locked <= 1'b0;
    end else if (ce && !dll_locked) begin // RULE6
      dll_cnt <= dll_cnt + 4'h1;
      if (dll_cnt == 4'(`ICDL_DLL_SETTLE - 1)) begin
        dll_code <= 7'(QTR_CODE); // RULE4
        dll_locked <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Phase tracking
  // ----------------------------------------
  icdl_pkg::icdl_rx_e rx_state;
  logic [1:0] sel;
  logic prev_bit;
  logic [1:0] off;
  logic edge_seen;
  logic hit_early;
  logic hit_late;
  logic [2:0] early_cnt;
  logic [2:0] late_cnt;
  logic shift_up;
  logic shift_dn;
  logic [4:0] good_cnt;
  logic dl_sel;
  assign edge_seen = ce && (rx_bit != prev_bit) && rx_state != icdl_pkg::RX_HUNT;
  assign off = phase - sel;
  assign hit_early = edge_seen && (off == 2'h1 || off == 2'h0); // RULE8
  assign hit_late = edge_seen && (off == 2'h3 || off == 2'h0); // RULE8
  assign shift_dn = hit_early && !hit_late && early_cnt + 3'h1 >= window;
  assign shift_up = hit_late && !hit_early && late_cnt + 3'h1 >= window;

  always_ff @(posedge aclk) begin
    if (resync) begin
      prev_bit <= 1'b0;
      early_cnt <= 3'h0;
      late_cnt <= 3'h0;
    end else if (ce) begin
      prev_bit <= rx_bit;
      if (shift_dn || shift_up) begin
        early_cnt <= 3'h0;
        late_cnt <= 3'h0;
      end else begin
        early_cnt <= early_cnt + 3'(hit_early && !hit_late);
        late_cnt <= late_cnt + 3'(hit_late && !hit_early);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (lane_rst) begin
      sel <= 2'h0;
      dl_sel <= 1'b0;
      phase_switch <= 1'b0;
      shift_direction_flag <= 1'b0;
    end else if (shift_up || shift_dn) begin
      sel <= shift_up ? sel + 2'h1 : sel - 2'h1;
      phase_switch <= ~phase_switch; // RULE10
      shift_direction_flag <= shift_up; // RULE11
      if ((shift_up && sel == 2'h3) || (shift_dn && sel == 2'h0)) begin
        dl_sel <= ~dl_sel; // RULE7
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (lane_rst) begin
      monitor_early_flag <= 1'b0;
      monitor_late_flag <= 1'b0;
    end else if (edge_seen) begin
      monitor_early_flag <= hit_early; // RULE8
      monitor_late_flag <= hit_late; // RULE12
    end
  end

  // ----------------------------------------
  // Lock state machine
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (resync) begin
      rx_state <= icdl_pkg::RX_HUNT;
      good_cnt <= 5'h0;
    end else if (ce) begin
      case (rx_state)
        icdl_pkg::RX_HUNT: begin
          if (sync2[2] && dll_locked) begin
            rx_state <= icdl_pkg::RX_TRACK; // RULE2
          end
        end
        icdl_pkg::RX_TRACK: begin
          if (shift_up || shift_dn || (hit_early && hit_late)) begin
            good_cnt <= 5'h0;
          end else if (edge_seen) begin
            good_cnt <= good_cnt + 5'h1;
            if (good_cnt == 5'(`ICDL_LOCK_EDGES - 1)) begin
              rx_state <= icdl_pkg::RX_LOCKED;
            end
          end
        end
        icdl_pkg::RX_LOCKED: begin
          rx_state <= icdl_pkg::RX_LOCKED;
        end
        default: begin
          rx_state <= icdl_pkg::RX_HUNT;
        end
      endcase
    end
  end

  // Lock flags hold across stream loss and pause
  always_ff @(posedge aclk) begin
    if (lane_rst) begin
      lock_valid <= 1'b0;
      recovery_locked <= 1'b0;
    end else if (ce && rx_state == icdl_pkg::RX_LOCKED) begin
      lock_valid <= 1'b1; // RULE2
      recovery_locked <= 1'b1; // RULE9
    end
  end

  // ----------------------------------------
  // Receive deserialiser
  // ----------------------------------------
  logic [WORD_W-1:0] rx_shift;
  logic [3:0] rx_cnt;
  logic rx_stb;
  logic [WORD_W-1:0] rx_full;
  assign rx_stb = ce && phase == sel && rx_state != icdl_pkg::RX_HUNT;
  assign rx_full = {rx_bit, rx_shift[WORD_W-1:1]};

  always_ff @(posedge aclk) begin
    if (resync) begin
      rx_shift <= '0;
      rx_cnt <= 4'h0;
      rx_fabric_clk <= 1'b0;
    end else if (rx_stb) begin
      rx_shift <= rx_full;
      rx_cnt <= (rx_cnt == 4'(WORD_W - 1)) ? 4'h0 : rx_cnt + 4'h1;
      if (rx_cnt == 4'(`ICDL_DIV_RATIO - 1) || rx_cnt == 4'(WORD_W - 1)) begin
        rx_fabric_clk <= ~rx_fabric_clk; // RULE1
      end
    end
  end

  icdl_word_rotate #(
    .WORD_W(WORD_W)
  ) u_rotate (
    .aclk(aclk),
    .clear(resync),
    .ce(ce),
    .rotate_stb(rotate_stb),
    .word_in(rx_full),
    .word_stb(rx_stb && rx_cnt == 4'(WORD_W - 1)), // RULE20
    .word_out(rx_word),
    .word_valid(rx_word_valid)
  );

  // ----------------------------------------
  // Transmit serialiser
  // ----------------------------------------
  icdl_pkg::icdl_tx_e tx_state;
  logic [WORD_W-1:0] tx_shift;
  logic [3:0] tx_cnt;
  logic tx_slot;
  assign tx_slot = ce && phase == 2'h0; // RULE15

  always_ff @(posedge aclk) begin
    if (resync) begin
      tx_state <= icdl_pkg::TX_WAIT;
      tx_shift <= '0;
      tx_cnt <= 4'h0;
      tx_word_take <= 1'b0;
      tx_fabric_clk <= 1'b0;
    end else if (ce) begin
      tx_word_take <= 1'b0;
      case (tx_state)
        icdl_pkg::TX_WAIT: begin
          if (tx_slot) begin
            tx_state <= icdl_pkg::TX_RUN;
            tx_shift <= tx_word;
            tx_word_take <= 1'b1; // RULE20
          end
        end
        icdl_pkg::TX_RUN: begin
          if (tx_slot) begin
            tx_cnt <= (tx_cnt == 4'(WORD_W - 1)) ? 4'h0 : tx_cnt + 4'h1;
            if (tx_cnt == 4'(`ICDL_DIV_RATIO - 1) || tx_cnt == 4'(WORD_W - 1)) begin
              tx_fabric_clk <= ~tx_fabric_clk; // RULE14
            end
            if (tx_cnt == 4'(WORD_W - 1)) begin
              tx_shift <= tx_word;
              tx_word_take <= 1'b1;
            end else begin
              tx_shift <= {1'b0, tx_shift[WORD_W-1:1]};
            end
          end
        end
        default: begin
          tx_state <= icdl_pkg::TX_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (lane_rst) begin
      tx_p <= 1'b0;
      tx_n <= 1'b1;
    end else if (ce) begin
      tx_p <= tx_state == icdl_pkg::TX_RUN && tx_shift[0];
      tx_n <= !(tx_state == icdl_pkg::TX_RUN && tx_shift[0]);
    end
  end

  assign delay_line_a_select = DIAG_OPTION ? {9'h0, dl_sel, dl_sel} : 11'h0; // RULE13
  assign delay_line_b_select = DIAG_OPTION ? {9'h0, ~dl_sel, ~dl_sel} : 11'h0;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic wr_stb;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] rd_data;
  logic rd_ok;
  logic wr_ok;
  assign wr_ok = wr_addr inside {`ICDL_OFS_CTRL, `ICDL_OFS_STATUS, `ICDL_OFS_DELAY,
    `ICDL_OFS_RXWORD};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_reset <= 1'b0;
      window <= `ICDL_WIN_RESET;
    end else if (wr_stb && wr_addr == `ICDL_OFS_CTRL && wr_strb[0]) begin
      soft_reset <= wr_data[`ICDL_CTRL_SRST];
      window <= wr_data[`ICDL_CTRL_WIN_HI:`ICDL_CTRL_WIN_LO];
    end
  end

  always_comb begin
    rd_data = 32'h0;
    rd_ok = 1'b1;
    case (s_axil_araddr)
      `ICDL_OFS_CTRL: rd_data = {25'h0, window, 3'h0, soft_reset};
      `ICDL_OFS_STATUS: rd_data = {22'h0, dl_sel, dll_locked, monitor_late_flag,
        monitor_early_flag, shift_direction_flag, phase_switch, rx_fabric_clk,
        tx_fabric_clk, recovery_locked, lock_valid};
      `ICDL_OFS_DELAY: rd_data = {25'h0, dll_code};
      `ICDL_OFS_RXWORD: rd_data = {22'h0, rx_word};
      default: rd_ok = 1'b0;
    endcase
  end

  icdl_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .awaddr(s_axil_awaddr),
    .awvalid(s_axil_awvalid),
    .awready(s_axil_awready),
    .wdata(s_axil_wdata),
    .wstrb(s_axil_wstrb),
    .wvalid(s_axil_wvalid),
    .wready(s_axil_wready),
    .bresp(s_axil_bresp),
    .bvalid(s_axil_bvalid),
    .bready(s_axil_bready),
    .araddr(s_axil_araddr),
    .arvalid(s_axil_arvalid),
    .arready(s_axil_arready),
    .rdata(s_axil_rdata),
    .rresp(s_axil_rresp),
    .rvalid(s_axil_rvalid),
    .rready(s_axil_rready),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );
endmodule // icdl_lane

// file: core/icdl_word_rotate.sv
// Rotation of the deserialised receive word
`timescale 1ns/1ns
`include "icdl_map.svh"
module icdl_word_rotate #(
  parameter int WORD_W = `ICDL_WORD_BITS
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic clear,
  input wire logic ce,
  // Control and data
  input wire logic rotate_stb,
  input wire logic [WORD_W-1:0] word_in,
  input wire logic word_stb,
  output logic [WORD_W-1:0] word_out,
  output logic word_valid
);
  logic [3:0] offset;

  function automatic logic [WORD_W-1:0] rot(input logic [WORD_W-1:0] w, input logic [3:0] n);
    logic [2*WORD_W-1:0] d;
    d = {w, w} >> n;
    return d[WORD_W-1:0];
  endfunction

  always_ff @(posedge aclk) begin
    if (clear) begin
      offset <= 4'h0; // RULE18
    end else if (ce && rotate_stb) begin
      offset <= (offset == 4'(WORD_W - 1)) ? 4'h0 : offset + 4'h1; // RULE19
    end
  end

  always_ff @(posedge aclk) begin
    if (clear) begin
      word_out <= '0;
      word_valid <= 1'b0;
    end else if (ce) begin
      word_valid <= word_stb;
      if (word_stb) begin
        word_out <= rot(word_in, offset); // RULE19
      end
    end
  end
endmodule // icdl_word_rotate

// file: pkg/icdl_map.svh
// Offsets, field positions, reset values and timing counts of the recovery lane
//
// Function
// RULE1: Fabric receive clock is bank clock divided five
// RULE2: Lock valid rises after stream valid, then sticks
// RULE3: Generator makes four 625 MHz quadrature phases
// RULE4: Delay code equals quarter of phase period
// RULE5: Word rotate input only with rotate option
// RULE6: Lane reset clears lane, not delay loop
// RULE7: Delay line selects toggle on A/B switch
// RULE8: Early/late flag edges inside minimum window
// RULE9: Recovery locked asserts and holds until reset
// RULE10: Phase switch output toggles per phase shift
// RULE11: Direction with early/late shows shift sense
// RULE12: Early and late with switch mean jitter
// RULE13: Diagnostic outputs only with diagnostic option; code gates only the delay line selects, other diagnostics always drive
// RULE14: Fixed ratio five, no divider choice
// RULE15: Transmit uses first generator output clock
// RULE16: Shared generator needs same rate and group
// RULE17: Stream valid driven only when stream valid
// RULE18: Pause toggle resyncs state, drops rotation
// RULE19: Each rotate shifts word by one position
// RULE20: One 10-bit word per fabric clock cycle
`ifndef ICDL_MAP_SVH
`define ICDL_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ICDL_OFS_CTRL 4'h0
`define ICDL_OFS_STATUS 4'h4
`define ICDL_OFS_DELAY 4'h8
`define ICDL_OFS_RXWORD 4'hc

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define ICDL_CTRL_SRST 0
`define ICDL_CTRL_WIN_LO 4
`define ICDL_CTRL_WIN_HI 6
`define ICDL_WIN_RESET 3'h1
`define ICDL_RESP_OKAY 2'h0
`define ICDL_RESP_SLVERR 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define ICDL_REF_MHZ 125
`define ICDL_PHASE_MHZ 625
`define ICDL_QTR_PS (1000000 / `ICDL_PHASE_MHZ / 4)
`define ICDL_DIV_RATIO 5
`define ICDL_WORD_BITS (2 * `ICDL_DIV_RATIO)
`define ICDL_LOCK_EDGES 16
`define ICDL_DLL_SETTLE 8

`endif

// file: pkg/icdl_pkg.sv
// Types of the recovery lane
`include "icdl_map.svh"
package icdl_pkg;
  typedef enum logic [1:0] {RX_HUNT, RX_TRACK, RX_LOCKED} icdl_rx_e;
  typedef enum logic {TX_WAIT, TX_RUN} icdl_tx_e;
  typedef logic [`ICDL_WORD_BITS-1:0] icdl_word_t;
endpackage

// file: tb/icdl_checker.sv
// Port checks of the recovery lane
`timescale 1ns/1ns
module icdl_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Inputs, and the bus write response valid output
  input wire logic stream_valid,
  input wire logic bank_clock_pause,
  input wire logic s_axil_bvalid,
  // Outputs
  input wire logic lock_valid,
  input wire logic recovery_locked,
  input wire logic rx_word_valid,
  input wire logic tx_fabric_clk,
  input wire logic [10:0] delay_line_a_select,
  input wire logic [10:0] delay_line_b_select,
  input wire logic monitor_early_flag,
  input wire logic monitor_late_flag,
  input wire logic phase_switch,
  input wire logic shift_direction_flag
);
  // ----
  // Quiet time since reset, write or pause
  // ----
  logic [5:0] quiet;
  logic [5:0] tx_gap;
  logic pause_q;
  always_ff @(posedge aclk) begin
    pause_q <= bank_clock_pause;
    tx_gap <= $changed(tx_fabric_clk) ? 6'h00 : tx_gap + 6'h01;
    if (!aresetn || s_axil_bvalid || pause_q != bank_clock_pause) begin
      quiet <= 6'h00;
    end else if (quiet != 6'h3f) begin
      quiet <= quiet + 6'h01;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || quiet < 6'h04);
  a_lock_after_stream: assert property ($rose(lock_valid) |-> $past(stream_valid, 3))
    else $error("lock valid rose without stream valid");
  a_lock_sticky: assert property (lock_valid |=> lock_valid)
    else $error("lock valid dropped");
  a_ready_sticky: assert property (recovery_locked |=> recovery_locked)
    else $error("recovery locked dropped");
  a_lock_pair: assert property ($rose(lock_valid) |-> recovery_locked)
    else $error("lock valid without recovery locked");
  a_select_pair: assert property (
    delay_line_a_select[10:1] == {9'h000, delay_line_a_select[0]} &&
    delay_line_b_select == (delay_line_a_select ^ 11'h003))
    else $error("delay line selects inconsistent");
  a_shift_not_jitter: assert property (
    $changed(phase_switch) |-> monitor_early_flag != monitor_late_flag)
    else $error("shift on jitter");
  a_shift_sense: assert property (
    $changed(phase_switch) |-> shift_direction_flag == monitor_late_flag)
    else $error("shift direction wrong");
  a_tx_half_period: assert property (
    $changed(tx_fabric_clk) && quiet > 6'h2c |-> tx_gap == 6'h13)
    else $error("tx fabric clock period wrong");
  a_word_pulse: assert property (rx_word_valid |=> !rx_word_valid [*8])
    else $error("rx word strobe too long or too dense");
endmodule // icdl_checker

bind icdl_lane icdl_checker chk_u (
  .aclk, .aresetn, .stream_valid, .bank_clock_pause, .s_axil_bvalid, .lock_valid,
  .recovery_locked, .rx_word_valid, .tx_fabric_clk, .delay_line_a_select,
  .delay_line_b_select, .monitor_early_flag, .monitor_late_flag, .phase_switch,
  .shift_direction_flag
);

// file: tb/icdl_remote_tx.sv
// Remote serial transmitter feeding the lane
`timescale 1ns/1ns
module icdl_remote_tx (
  // Clock and control
  input wire logic aclk,
  input wire logic en,
  input wire logic slow,
  input wire logic [9:0] word,
  // Serial pair
  output logic rx_p,
  output logic rx_n
);
  logic [2:0] ph = 3'h0;
  logic [3:0] idx = 4'h0;
  logic last = 1'b0;
  // Idle line shows the inverse of the last bit
  always_ff @(posedge aclk) begin
    if (!en) begin
      rx_p <= ~last;
      rx_n <= last;
      ph <= 3'h0;
    end else begin
      ph <= (ph == (slow ? 3'h4 : 3'h3)) ? 3'h0 : ph + 3'h1;
      if (ph == 3'h0) begin
        rx_p <= word[idx];
        rx_n <= ~word[idx];
        last <= word[idx];
        idx <= (idx == 4'h9) ? 4'h0 : idx + 4'h1;
      end
    end
  end
endmodule // icdl_remote_tx

// file: tb/tb.sv
// Self-checking bench of the recovery lane
`timescale 1ns/1ns
`include "icdl_map.svh"
module tb;
  localparam logic [9:0] SENT = 10'h0f1;
  localparam int TAP = 25;
  logic aclk, aresetn, ce, s_axil_awvalid, s_axil_wvalid, s_axil_bready;
  logic s_axil_arvalid, s_axil_rready, s_axil_awready, s_axil_wready;
  logic s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [3:0] s_axil_awaddr, s_axil_araddr, s_axil_wstrb;
  logic [31:0] s_axil_wdata, s_axil_rdata;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic rx_p, rx_n, tx_p, tx_n, stream_valid, bank_clock_pause, word_rotate;
  logic rx_fabric_clk, rx_word_valid, lock_valid, tx_fabric_clk, tx_word_take;
  logic [9:0] rx_word, tx_word;
  logic [10:0] delay_line_a_select, delay_line_b_select;
  logic monitor_early_flag, monitor_late_flag, recovery_locked, phase_switch;
  logic shift_direction_flag, tx_en, slow;
  int miscompares, n_tests;
  icdl_lane #(.TAP_PS(TAP)) dut_u (.*);
  icdl_remote_tx rtx_u (.aclk, .en(tx_en), .slow, .word(SENT), .rx_p, .rx_n);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // ----
  // Shared tasks
  // ----
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic is_rot(input logic [9:0] w, input logic [9:0] ref_w);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < 10; k++) hit = hit | (w === ((ref_w >> k) | (ref_w << (10 - k))));
    return hit;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    logic ad, wd;
    t = 0;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    do begin
      @(posedge aclk);
      ad = ad | s_axil_awready;
      wd = wd | s_axil_wready;
      s_axil_awvalid <= !ad;
      s_axil_wvalid <= !wd;
    end while (!(ad && wd) && ++t < 100);
    do @(posedge aclk); while (!s_axil_bvalid && ++t < 100);
    r = s_axil_bresp;
    s_axil_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    @(posedge aclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do @(posedge aclk); while (!s_axil_arready && ++t < 100);
    s_axil_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axil_rvalid && ++t < 100);
    d = s_axil_rdata;
    r = s_axil_rresp;
    s_axil_rready <= 1'b0;
  endtask
  task automatic get_word(output logic [9:0] w);
    int t;
    t = 0;
    do @(posedge aclk); while (rx_word_valid !== 1'b1 && ++t < 200);
    chk("rx word strobe", rx_word_valid, 1);
    w = rx_word;
  endtask
  task automatic rotate_once(output logic [9:0] w);
    word_rotate <= 1'b1;
    repeat (3) @(posedge aclk);
    word_rotate <= 1'b0;
    get_word(w);
    get_word(w);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_lock;
    logic [31:0] d;
    logic [1:0] r;
    int t;
    t = 0;
    tx_en <= 1'b1;
    repeat (400) @(posedge aclk);
    chk("lock before stream", lock_valid, 0);
    chk("locked before stream", recovery_locked, 0);
    stream_valid <= 1'b1;
    do @(posedge aclk); while (!lock_valid && ++t < 6000);
    chk("lock valid", lock_valid, 1);
    rd(`ICDL_OFS_STATUS, d, r);
    chk("status lock bits", d[1:0], 2'h3);
    rd(`ICDL_OFS_DELAY, d, r);
    chk("delay code", d[6:0], `ICDL_QTR_PS / TAP);
    rd(4'h2, d, r);
    chk("unmapped resp", r, `ICDL_RESP_SLVERR);
  endtask
  task automatic t_fabric;
    logic c0;
    int n;
    for (int i = 0; i < 2; i++) begin
      for (int j = 0; j < 2; j++) begin
        n = 0;
        c0 = i ? tx_fabric_clk : rx_fabric_clk;
        while ((i ? tx_fabric_clk : rx_fabric_clk) === c0 && n < 100) begin
          @(posedge aclk);
          n++;
        end
      end
      chk(i ? "tx clock half period" : "rx clock half period", n, 20);
    end
  endtask
  task automatic t_rotate;
    logic [9:0] w;
    int k;
    k = 0;
    get_word(w);
    while (w !== SENT && k < 10) begin
      rotate_once(w);
      k++;
    end
    chk("aligned word", w, SENT);
    rotate_once(w);
    chk("rotated word", w, {SENT[0], SENT[9:1]});
    bank_clock_pause <= 1'b1;
    get_word(w);
    get_word(w);
    chk("lock after pause", lock_valid, 1);
    chk("word after pause", is_rot(w, SENT), 1);
  endtask
  task automatic t_disturb;
    int sw;
    logic p0;
    tx_en <= 1'b0;
    repeat (300) @(posedge aclk);
    chk("lock kept idle", lock_valid, 1);
    tx_en <= 1'b1;
    sw = 0;
    p0 = phase_switch;
    slow <= 1'b1;
    repeat (2000) begin
      @(posedge aclk);
      if (phase_switch !== p0) sw++;
      p0 = phase_switch;
    end
    slow <= 1'b0;
    chk("phase shifts seen", sw > 0, 1);
    chk("locked kept drift", recovery_locked, 1);
  endtask
  task automatic t_tx_soft;
    logic [9:0] s;
    logic [31:0] d;
    logic [1:0] r;
    int t;
    t = 0;
    do @(posedge aclk); while (!tx_word_take && ++t < 100);
    chk("tx word take", tx_word_take, 1);
    for (int i = 0; i < 10; i++) begin
      repeat (4) @(posedge aclk);
      s = {tx_p, s[9:1]};
      chk("tx pair", tx_n, !tx_p);
    end
    chk("tx serial word", is_rot(s, tx_word), 1);
    wr(`ICDL_OFS_CTRL, 32'h11, r);
    rd(`ICDL_OFS_STATUS, d, r);
    chk("dll kept", d[8], 1);
    chk("lane cleared", d[0], 0);
    rd(`ICDL_OFS_DELAY, d, r);
    chk("delay code kept", d[6:0], `ICDL_QTR_PS / TAP);
    wr(`ICDL_OFS_CTRL, 32'h10, r);
    chk("ctrl resp", r, `ICDL_RESP_OKAY);
  endtask
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    miscompares++;
    complete_run();
  end
  initial begin
    {aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid} = '0;
    {s_axil_rready, stream_valid, bank_clock_pause, word_rotate, tx_en, slow} = '0;
    {s_axil_awaddr, s_axil_araddr, s_axil_wdata} = '0;
    {miscompares, n_tests} = '0;
    ce = 1'b1;
    s_axil_wstrb = 4'hf;
    tx_word = 10'h2c5;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_lock();
    t_fabric();
    t_rotate();
    t_disturb();
    t_tx_soft();
    complete_run();
  end
endmodule // tb
